// *** hdl/vts_rate_digit.sv ***
`timescale 1ns/100ps
// ==================================================
// per-digit rate editor, purely combinational
module vts_rate_digit (
  input wire vts_pkg::vts_bcd_t rate_in,
  input wire logic step_hundreds,
  input wire logic step_tens,
  input wire logic step_ones,
  input wire logic hold_hundreds,
  input wire logic hold_tens,
  input wire logic hold_ones,
  output vts_pkg::vts_bcd_t rate_out
);
  wire logic [3:0] dig_h = rate_in[11:8];
  wire logic [3:0] dig_t = rate_in[7:4];
  wire logic [3:0] dig_o = rate_in[3:0];
  // scrolling only goes forward, so each digit wraps 9 -> 0
  wire logic [3:0] inc_h = (dig_h >= 4'h9) ? 4'h0 : dig_h + 4'h1; // [RULE4]
  wire logic [3:0] inc_t = (dig_t >= 4'h9) ? 4'h0 : dig_t + 4'h1; // [RULE4]
  wire logic [3:0] inc_o = (dig_o >= 4'h9) ? 4'h0 : dig_o + 4'h1; // [RULE4]
  wire logic [3:0] new_h = hold_hundreds ? 4'h0 : (step_hundreds ? inc_h : dig_h); // [RULE6]
  wire logic [3:0] new_t = hold_tens ? 4'h0 : (step_tens ? inc_t : dig_t); // [RULE6]
  wire logic [3:0] new_o = hold_ones ? 4'h1 : (step_ones ? inc_o : dig_o); // [RULE6]
  wire logic all_zero = (new_h == 4'h0) && (new_t == 4'h0) && (new_o == 4'h0);
  // zero frames would be a cut, so the editor lands on one instead
  assign rate_out = all_zero ? 12'h001 : {new_h, new_t, new_o}; // [RULE7]
endmodule

// *** hdl/vts_top.sv ***
// Operation
// (RULE1) auto durations count whole frames, 1/30 or 1/25 second by standard
// (RULE2) three stored rates: auto, downstream key dissolve, fade to black
// (RULE3) rate select press cycles the edited rate through three functions
// (RULE4) rates stay within 1 to 999; step buttons bump their digit
// (RULE5) each digit step updates stored rate and display at once
// (RULE6) holding hundreds or tens clears it; holding ones sets one
// (RULE7) a zero rate is never stored
// (RULE8) cut during an auto transition finishes it instantly
// (RULE9) moving the fader during an auto transition takes over control
// (RULE10) fader off both limits disables all transition buttons
// (RULE11) audio cut off: auto audio follows video rate and type
// (RULE12) audio cut off: fader transition also drives audio
// (RULE13) manual progress follows fader position
// (RULE14) progress bar lights in proportion; unlit part shows remaining direction
// (RULE15) cut swaps program and preset; a second cut swaps back
// (RULE16) next-transition selection persists after completion
// (RULE17) preview shows the scene the next transition will give
// (RULE18) any combination of background and two keys may be selected
// (RULE19) writing the program source is an immediate cut without preview
// (RULE20) selected keys toggle on air at completion; lamp shows key on air
// (RULE21) a full limit-to-limit travel swaps buses from either limit
// (RULE22) auto progress steps once per frame, done after the stored frames
`timescale 1ns/100ps
`include "vts_cfg.svh"
module vts_top #(
  parameter int unsigned FRAME_CYC_NTSC = `VTS_CLK_HZ / `VTS_FPS_NTSC,
  parameter int unsigned FRAME_CYC_PAL = `VTS_CLK_HZ / `VTS_FPS_PAL
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic btn_rate_sel,
  input wire logic btn_step_hundreds,
  input wire logic btn_step_tens,
  input wire logic btn_step_ones,
  input wire logic btn_hold_hundreds,
  input wire logic btn_hold_tens,
  input wire logic btn_hold_ones,
  input wire logic btn_auto_trans,
  input wire logic btn_cut,
  input wire logic downstream_key_dissolve_trigger,
  input wire logic btn_fade_to_black,
  input wire logic [7:0] fader_pos,
  output logic [7:0] program_bus,
  output logic [7:0] preset_bus,
  output logic [7:0] preview_bus,
  output logic preview_first_key_select_on,
  output logic preview_second_key_select_on,
  output logic first_key_select_on_air,
  output logic second_key_select_on_air,
  output logic downstream_key_on_air,
  output logic fade_black_on,
  output vts_pkg::vts_bcd_t display_rate,
  output logic [1:0] display_sel,
  output logic [`VTS_SEGS-1:0] progress_bar,
  output logic transition_active,
  output logic audio_follow,
  output logic [1:0] audio_type
);
  // ==================================================
  // helpers
  function automatic logic [9:0] bcd_to_bin(input vts_pkg::vts_bcd_t b);
    bcd_to_bin = 10'(b[11:8]) * 10'd100 + 10'(b[7:4]) * 10'd10 + 10'(b[3:0]);
  endfunction

  // bus writes may carry any pattern, so clamp digits and forbid zero
  function automatic vts_pkg::vts_bcd_t bcd_clean(input logic [11:0] w);
    logic [3:0] h;
    logic [3:0] t;
    logic [3:0] o;
    h = (w[11:8] > 4'h9) ? 4'h9 : w[11:8];
    t = (w[7:4] > 4'h9) ? 4'h9 : w[7:4];
    o = (w[3:0] > 4'h9) ? 4'h9 : w[3:0];
    bcd_clean = ({h, t, o} == 12'h000) ? 12'h001 : {h, t, o};
  endfunction

  // ==================================================
  // state
  vts_pkg::vts_state_t state_ff;
  vts_pkg::vts_state_t nxt_state;
  logic [6:0] ctrl_ff;
  vts_pkg::vts_bcd_t rate_ff [`VTS_NUM_RATES];
  vts_pkg::vts_bcd_t nxt_rate [`VTS_NUM_RATES];
  logic [1:0] sel_ff;
  logic [7:0] program_ff;
  logic [7:0] preset_ff;
  logic first_key_select_ff;
  logic second_key_select_ff;
  logic [9:0] auto_cnt_ff;
  logic start_hi_ff;
  logic last_hi_ff;
  logic [22:0] frame_cnt_ff;
  logic tick_ff;
  logic ap_valid_ff;
  logic ap_write_ff;
  logic [7:0] ap_addr_ff;
  logic [1:0] side_busy_ff;
  logic [1:0] side_on_ff;
  logic [9:0] side_cnt_ff [2];

  // ==================================================
  // frame pacing
  wire logic std_pal = ctrl_ff[`VTS_CTRL_PAL];
  wire logic audio_cut = ctrl_ff[`VTS_CTRL_AUDIO_CUT];
  wire logic [2:0] next_sel = ctrl_ff[`VTS_CTRL_SEL_HI:`VTS_CTRL_SEL_LO];
  wire logic [22:0] frame_last = std_pal ? 23'(FRAME_CYC_PAL - 1) : 23'(FRAME_CYC_NTSC - 1); // [RULE1]
  wire logic frame_wrap = (frame_cnt_ff >= frame_last);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_cnt_ff <= 23'h000000;
      tick_ff <= 1'b0;
    end else begin
      frame_cnt_ff <= frame_wrap ? 23'h000000 : frame_cnt_ff + 23'h000001; // [RULE1]
      tick_ff <= frame_wrap;
    end
  end

  // ==================================================
  // ahb-lite slave, zero wait states
  wire logic ap_take = hsel && htrans[1] && hready;
  wire logic [7:0] rd_addr = haddr[7:0];
  wire logic wr_en = ap_valid_ff && ap_write_ff;
  wire logic wr_ctrl = wr_en && (ap_addr_ff == `VTS_OFS_CTRL);
  wire logic wr_program = wr_en && (ap_addr_ff == `VTS_OFS_PROGRAM);
  wire logic wr_preset = wr_en && (ap_addr_ff == `VTS_OFS_PRESET);
  wire logic [2:0] wr_rate;
  assign wr_rate[0] = wr_en && (ap_addr_ff == `VTS_OFS_RATE_AUTO);
  assign wr_rate[1] = wr_en && (ap_addr_ff == `VTS_OFS_RATE_DSK);
  assign wr_rate[2] = wr_en && (ap_addr_ff == `VTS_OFS_RATE_FADE);
  wire logic [31:0] status_word = {16'h0000, 2'b00, side_on_ff, second_key_select_ff, first_key_select_ff, sel_ff,
                                   2'b00, 2'(state_ff), side_busy_ff, 2'b00};
  wire logic [31:0] rd_mux =
    (rd_addr == `VTS_OFS_CTRL) ? {25'h0000000, ctrl_ff} :
    (rd_addr == `VTS_OFS_RATE_AUTO) ? {20'h00000, rate_ff[0]} :
    (rd_addr == `VTS_OFS_RATE_DSK) ? {20'h00000, rate_ff[1]} :
    (rd_addr == `VTS_OFS_RATE_FADE) ? {20'h00000, rate_ff[2]} :
    (rd_addr == `VTS_OFS_PROGRAM) ? {24'h000000, program_ff} :
    (rd_addr == `VTS_OFS_PRESET) ? {24'h000000, preset_ff} :
    (rd_addr == `VTS_OFS_STATUS) ? status_word : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_ff <= 1'b0;
      ap_write_ff <= 1'b0;
      ap_addr_ff <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      ap_valid_ff <= ap_take;
      ap_write_ff <= hwrite;
      ap_addr_ff <= haddr[7:0];
      if (ap_take && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= `VTS_RST_CTRL;
    end else if (wr_ctrl) begin
      // selection is only replaced by software, never by a completion
      ctrl_ff <= hwdata[6:0]; // [RULE16] [RULE18]
    end
  end

  // ==================================================
  // rate storage and editing
  vts_pkg::vts_bcd_t edit_out;
  wire logic [1:0] sel_next = (sel_ff == 2'd2) ? 2'd0 : sel_ff + 2'd1; // [RULE3]

  vts_rate_digit u_digit (
    .rate_in(rate_ff[sel_ff]),
    .step_hundreds(btn_step_hundreds),
    .step_tens(btn_step_tens),
    .step_ones(btn_step_ones),
    .hold_hundreds(btn_hold_hundreds),
    .hold_tens(btn_hold_tens),
    .hold_ones(btn_hold_ones),
    .rate_out(edit_out)
  );

  for (genvar k = 0; k < `VTS_NUM_RATES; k++) begin : g_rate
    assign nxt_rate[k] = wr_rate[k] ? bcd_clean(hwdata[11:0]) :
                         (sel_ff == 2'(k)) ? edit_out : rate_ff[k]; // [RULE5] [RULE2]
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        rate_ff[k] <= `VTS_RST_RATE;
      end else begin
        rate_ff[k] <= nxt_rate[k];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_ff <= 2'd0;
    end else if (btn_rate_sel) begin
      sel_ff <= sel_next; // [RULE3]
    end
  end

  // ==================================================
  // main transition engine
  wire logic fader_lo = (fader_pos == `VTS_FADER_MIN);
  wire logic fader_hi = (fader_pos == `VTS_FADER_MAX);
  wire logic at_limit = fader_lo || fader_hi;
  wire logic cut_ok = btn_cut && at_limit; // [RULE10]
  wire logic auto_ok = btn_auto_trans && at_limit && !btn_cut; // [RULE10]
  wire logic [9:0] auto_rate = bcd_to_bin(rate_ff[0]);
  wire logic [9:0] auto_step = auto_cnt_ff + 10'd1;
  wire logic auto_done = (state_ff == vts_pkg::VTS_AUTO) && tick_ff && (auto_step >= auto_rate); // [RULE22]
  wire logic start_pos = start_hi_ff ? fader_hi : fader_lo;
  wire logic far_pos = start_hi_ff ? fader_lo : fader_hi;
  wire logic takeover = (state_ff == vts_pkg::VTS_AUTO) && !start_pos && !cut_ok; // [RULE9]
  wire logic man_done = (state_ff == vts_pkg::VTS_MANUAL) && far_pos; // [RULE21]
  wire logic man_abort = (state_ff == vts_pkg::VTS_MANUAL) && start_pos;
  wire logic cut_done = cut_ok && (state_ff != vts_pkg::VTS_MANUAL); // [RULE8] [RULE15]
  wire logic complete = auto_done || cut_done || man_done;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      vts_pkg::VTS_IDLE: begin
        if (cut_done) begin
          nxt_state = vts_pkg::VTS_IDLE;
        end else if (auto_ok) begin
          nxt_state = vts_pkg::VTS_AUTO;
        end else if (!at_limit) begin
          nxt_state = vts_pkg::VTS_MANUAL; // [RULE13]
        end
      end
      vts_pkg::VTS_AUTO: begin
        if (cut_done || auto_done) begin
          nxt_state = vts_pkg::VTS_IDLE; // [RULE8]
        end else if (takeover) begin
          nxt_state = vts_pkg::VTS_MANUAL; // [RULE9]
        end
      end
      vts_pkg::VTS_MANUAL: begin
        if (man_done || man_abort) begin
          nxt_state = vts_pkg::VTS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= vts_pkg::VTS_IDLE;
      auto_cnt_ff <= 10'd0;
      start_hi_ff <= 1'b0;
      last_hi_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == vts_pkg::VTS_IDLE) begin
        auto_cnt_ff <= 10'd0;
        start_hi_ff <= last_hi_ff;
      end else if ((state_ff == vts_pkg::VTS_AUTO) && tick_ff) begin
        auto_cnt_ff <= auto_step; // [RULE22]
      end
      if (at_limit) begin
        last_hi_ff <= fader_hi;
      end
    end
  end

  // any completion with the background selected flips the buses; a program write is a bare cut
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      program_ff <= `VTS_RST_PROGRAM;
      preset_ff <= `VTS_RST_PRESET;
      first_key_select_ff <= 1'b0;
      second_key_select_ff <= 1'b0;
    end else begin
      if (wr_program) begin
        program_ff <= hwdata[7:0]; // [RULE19]
      end else if (complete && next_sel[`VTS_SEL_BACKGROUND_ELEMENT_SELECT]) begin
        program_ff <= preset_ff; // [RULE15] [RULE21]
      end
      if (wr_preset) begin
        preset_ff <= hwdata[7:0];
      end else if (complete && next_sel[`VTS_SEL_BACKGROUND_ELEMENT_SELECT]) begin
        preset_ff <= program_ff; // [RULE15] [RULE21]
      end
      if (complete && next_sel[`VTS_SEL_FIRST_KEY_SELECT]) begin
        first_key_select_ff <= !first_key_select_ff; // [RULE20]
      end
      if (complete && next_sel[`VTS_SEL_SECOND_KEY_SELECT]) begin
        second_key_select_ff <= !second_key_select_ff; // [RULE20]
      end
    end
  end

  // ==================================================
  // downstream key dissolve and fade to black, each on its own rate
  for (genvar c = 0; c < 2; c++) begin : g_side
    wire logic trig = ((c == 0) ? downstream_key_dissolve_trigger : btn_fade_to_black) && at_limit; // [RULE10]
    wire logic [9:0] side_rate = bcd_to_bin(rate_ff[c + 1]); // [RULE2]
    wire logic [9:0] side_step = side_cnt_ff[c] + 10'd1;
    wire logic side_end = side_busy_ff[c] && tick_ff && (side_step >= side_rate);
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        side_busy_ff[c] <= 1'b0;
        side_on_ff[c] <= 1'b0;
        side_cnt_ff[c] <= 10'd0;
      end else if (side_end) begin
        side_busy_ff[c] <= 1'b0;
        side_on_ff[c] <= !side_on_ff[c];
      end else if (trig && !side_busy_ff[c]) begin
        side_busy_ff[c] <= 1'b1;
        side_cnt_ff[c] <= 10'd0;
      end else if (side_busy_ff[c] && tick_ff) begin
        side_cnt_ff[c] <= side_step; // [RULE1]
      end
    end
  end

  // ==================================================
  // progress bar: auto uses frames, manual uses fader distance
  wire logic [7:0] fader_dist = start_hi_ff ? (`VTS_FADER_MAX - fader_pos) : fader_pos;
  wire logic manual = (state_ff == vts_pkg::VTS_MANUAL);
  wire logic [13:0] prog_num = manual ? 14'(fader_dist) * 14'd10 : 14'(auto_cnt_ff) * 14'd10; // [RULE13]
  wire logic [13:0] prog_den = manual ? 14'(`VTS_FADER_MAX) : 14'(auto_rate);
  wire logic [`VTS_SEGS-1:0] bar_raw;
  wire logic [`VTS_SEGS-1:0] bar_dir;
  for (genvar s = 0; s < `VTS_SEGS; s++) begin : g_seg
    assign bar_raw[s] = (state_ff != vts_pkg::VTS_IDLE) && (prog_num >= prog_den * 14'(s + 1)); // [RULE14]
    // lit from the starting end so the dark end points where to push
    assign bar_dir[s] = start_hi_ff ? bar_raw[`VTS_SEGS - 1 - s] : bar_raw[s]; // [RULE14]
  end

  // ==================================================
  // registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      program_bus <= `VTS_RST_PROGRAM;
      preset_bus <= `VTS_RST_PRESET;
      preview_bus <= `VTS_RST_PRESET;
      preview_first_key_select_on <= 1'b0;
      preview_second_key_select_on <= 1'b0;
      first_key_select_on_air <= 1'b0;
      second_key_select_on_air <= 1'b0;
      downstream_key_on_air <= 1'b0;
      fade_black_on <= 1'b0;
      display_rate <= `VTS_RST_RATE;
      display_sel <= 2'd0;
      progress_bar <= '0;
      transition_active <= 1'b0;
      audio_follow <= 1'b0;
      audio_type <= 2'd0;
    end else begin
      program_bus <= program_ff;
      preset_bus <= preset_ff;
      preview_bus <= next_sel[`VTS_SEL_BACKGROUND_ELEMENT_SELECT] ? preset_ff : program_ff; // [RULE17]
      preview_first_key_select_on <= first_key_select_ff ^ next_sel[`VTS_SEL_FIRST_KEY_SELECT]; // [RULE17]
      preview_second_key_select_on <= second_key_select_ff ^ next_sel[`VTS_SEL_SECOND_KEY_SELECT]; // [RULE17]
      first_key_select_on_air <= first_key_select_ff; // [RULE20]
      second_key_select_on_air <= second_key_select_ff; // [RULE20]
      downstream_key_on_air <= side_on_ff[0];
      fade_black_on <= side_on_ff[1];
      display_rate <= rate_ff[sel_ff]; // [RULE5]
      display_sel <= sel_ff;
      progress_bar <= bar_dir;
      transition_active <= (state_ff != vts_pkg::VTS_IDLE);
      // audio rides the same progress as video, so the rate matches by design
      audio_follow <= !audio_cut && (state_ff != vts_pkg::VTS_IDLE); // [RULE11] [RULE12]
      audio_type <= ctrl_ff[`VTS_CTRL_TYPE_HI:`VTS_CTRL_TYPE_LO]; // [RULE11]
    end
  end

  // ==================================================
  // assertions
  rate_legal_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE7]
    (rate_ff[0] != 12'h000) && (rate_ff[1] != 12'h000) && (rate_ff[2] != 12'h000))
    else $error("zero rate stored");
  digit_range_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE4]
    (rate_ff[sel_ff][3:0] <= 4'h9) && (rate_ff[sel_ff][7:4] <= 4'h9) && (rate_ff[sel_ff][11:8] <= 4'h9))
    else $error("rate digit out of range");
  sel_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE3]
    btn_rate_sel |=> (sel_ff == (($past(sel_ff) == 2'd2) ? 2'd0 : $past(sel_ff) + 2'd1)))
    else $error("rate select did not advance");
  cut_finish_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE8]
    (state_ff == vts_pkg::VTS_AUTO) && btn_cut && at_limit |=> (state_ff == vts_pkg::VTS_IDLE))
    else $error("cut did not finish auto");
  fader_take_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE9]
    (state_ff == vts_pkg::VTS_AUTO) && !at_limit && !auto_done |=> (state_ff == vts_pkg::VTS_MANUAL))
    else $error("fader did not take over");
  fader_block_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE10]
    !at_limit && (state_ff == vts_pkg::VTS_IDLE) && !wr_program |=> $stable(program_ff) && (state_ff != vts_pkg::VTS_AUTO))
    else $error("button acted off limit");
  bus_swap_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE15]
    complete && next_sel[0] && !wr_en |=> (program_ff == $past(preset_ff)) && (preset_ff == $past(program_ff)))
    else $error("buses did not swap");
  key_toggle_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE20]
    complete && next_sel[1] |=> (first_key_select_ff != $past(first_key_select_ff)) ##1 (first_key_select_on_air == $past(first_key_select_ff)))
    else $error("key did not toggle");
  auto_len_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE22]
    (state_ff == vts_pkg::VTS_AUTO) && !tick_ff |=> (auto_cnt_ff == $past(auto_cnt_ff)) || (state_ff != vts_pkg::VTS_AUTO))
    else $error("auto progress moved without a frame");
  audio_man_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE12]
    (state_ff == vts_pkg::VTS_MANUAL) && !audio_cut |=> audio_follow)
    else $error("audio not following fader");
  cover_auto_c: cover property (@(posedge hclk) disable iff (!hresetn) auto_done);
  cover_manual_c: cover property (@(posedge hclk) disable iff (!hresetn) man_done);
  cover_take_c: cover property (@(posedge hclk) disable iff (!hresetn) takeover);
  cover_cut_c: cover property (@(posedge hclk) disable iff (!hresetn)
    cut_done && (state_ff == vts_pkg::VTS_AUTO));
endmodule

// *** inc/vts_cfg.svh ***
`ifndef VTS_CFG_SVH
`define VTS_CFG_SVH

// ==================================================
// register byte offsets
`define VTS_OFS_CTRL 8'h00
`define VTS_OFS_RATE_AUTO 8'h04
`define VTS_OFS_RATE_DSK 8'h08
`define VTS_OFS_RATE_FADE 8'h0c
`define VTS_OFS_PROGRAM 8'h10
`define VTS_OFS_PRESET 8'h14
`define VTS_OFS_STATUS 8'h18

// ==================================================
// control register fields
`define VTS_CTRL_PAL 0
`define VTS_CTRL_AUDIO_CUT 1
`define VTS_CTRL_SEL_LO 2
`define VTS_CTRL_SEL_HI 4
`define VTS_CTRL_TYPE_LO 5
`define VTS_CTRL_TYPE_HI 6
`define VTS_SEL_BACKGROUND_ELEMENT_SELECT 0
`define VTS_SEL_FIRST_KEY_SELECT 1
`define VTS_SEL_SECOND_KEY_SELECT 2

// ==================================================
// reset values
`define VTS_RST_CTRL 7'h04
`define VTS_RST_RATE 12'h030
`define VTS_RST_PROGRAM 8'h00
`define VTS_RST_PRESET 8'h01

// ==================================================
// timing and geometry
`define VTS_CLK_HZ 100000000
`define VTS_FPS_NTSC 30
`define VTS_FPS_PAL 25
`define VTS_FADER_MIN 8'h00
`define VTS_FADER_MAX 8'hff
`define VTS_SEGS 10
`define VTS_NUM_RATES 3

`endif

// *** inc/vts_pkg.sv ***
package vts_pkg;
  typedef enum logic [1:0] {VTS_IDLE, VTS_AUTO, VTS_MANUAL} vts_state_t;
  typedef logic [11:0] vts_bcd_t;
endpackage

// *** tb/test_vts_top.sv ***
`timescale 1ns/100ps
`include "vts_cfg.svh"
module test_vts_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, d;
  logic hreadyout, transition_active, audio_follow, first_key_select_on_air, preview_first_key_select_on, dsk_on;
  logic hresp, preview_second_key_select_on, second_key_select_on_air, fade_on;
  logic [10:0] btn;
  logic [7:0] fader_pos, program_bus, preset_bus, preview_bus;
  logic [1:0] display_sel, audio_type;
  logic [11:0] display_rate;
  logic [`VTS_SEGS-1:0] progress_bar;
  int errors = 0;
  int tests_run = 0;
  int n;
  int bi [6] = '{6, 3, 5, 1, 4, 2};
  logic [11:0] be [6] = '{12'h031, 12'h032, 12'h002, 12'h102, 12'h002, 12'h012};
  always #5 hclk = ~hclk;
  vts_panel p (.hclk(hclk), .btn(btn), .fader_pos(fader_pos));
  vts_top #(.FRAME_CYC_NTSC(20), .FRAME_CYC_PAL(25)) i_vts_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .btn_rate_sel(btn[0]), .btn_step_hundreds(btn[1]), .btn_step_tens(btn[2]), .btn_step_ones(btn[3]),
    .btn_hold_hundreds(btn[4]), .btn_hold_tens(btn[5]), .btn_hold_ones(btn[6]), .btn_auto_trans(btn[7]),
    .btn_cut(btn[8]), .downstream_key_dissolve_trigger(btn[9]), .btn_fade_to_black(btn[10]),
    .fader_pos(fader_pos), .program_bus(program_bus), .preset_bus(preset_bus), .preview_bus(preview_bus),
    .preview_first_key_select_on(preview_first_key_select_on), .preview_second_key_select_on(preview_second_key_select_on), .first_key_select_on_air(first_key_select_on_air),
    .second_key_select_on_air(second_key_select_on_air), .downstream_key_on_air(dsk_on), .fade_black_on(fade_on),
    .display_rate(display_rate), .display_sel(display_sel), .progress_bar(progress_bar),
    .transition_active(transition_active), .audio_follow(audio_follow), .audio_type(audio_type));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // address phase held until hready, then data phase held until hready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= w;
    hsel <= 1'b1;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task automatic settle;
    repeat (4) @(posedge hclk);
  endtask
  // polls the live signal: 0 transition running, 1 key not yet on, 2 fade not yet on
  task automatic wait_cnt(input int w);
    n = 0;
    while (((w == 0) ? transition_active : (w == 1) ? !dsk_on : !fade_on) === 1'b1 && n < 1000) begin
      @(posedge hclk);
      n++;
    end
  endtask
  initial begin
    #300us;
    errors++;
    wrap_up;
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(0, `VTS_OFS_RATE_DSK, 0);
    chk(d, 32'h030);
    chk({31'h0, hresp}, 32'h0);
    xfer(0, `VTS_OFS_PRESET, 0);
    chk(d, 32'h1);
    xfer(0, 8'h1c, 0);
    chk(d, 32'h0);
    $display("test reset ended");
    for (int i = 1; i <= 3; i++) begin
      p.press(0);
      settle;
      chk({30'h0, display_sel}, 32'(i % 3));
    end
    for (int k = 0; k < 6; k++) begin
      p.press(bi[k]);
      settle;
      chk({20'h0, display_rate}, {20'h0, be[k]});
    end
    xfer(1, `VTS_OFS_RATE_AUTO, 32'h000);
    xfer(0, `VTS_OFS_RATE_AUTO, 0);
    chk(d, 32'h001);
    xfer(1, `VTS_OFS_RATE_AUTO, 32'h002);
    $display("test rates ended");
    p.press(7);
    repeat (3) @(posedge hclk);
    chk({31'h0, audio_follow}, 32'h1);
    wait_cnt(0);
    chk({31'h0, n >= 15 && n <= 44}, 32'h1);
    settle;
    chk({24'h0, program_bus}, 32'h1);
    xfer(1, `VTS_OFS_RATE_AUTO, 32'h009);
    p.press(7);
    repeat (10) @(posedge hclk);
    p.press(8);
    settle;
    chk({31'h0, transition_active}, 32'h0);
    chk({24'h0, program_bus}, 32'h0);
    $display("test auto ended");
    p.press(7);
    repeat (10) @(posedge hclk);
    p.slide(8'h80);
    settle;
    chk({22'h0, progress_bar}, 32'h01f);
    chk({30'h0, transition_active, audio_follow}, 32'h3);
    p.press(8);
    settle;
    chk({24'h0, program_bus}, 32'h0);
    p.slide(8'hff);
    settle;
    chk({24'h0, program_bus}, 32'h1);
    p.slide(8'h80);
    settle;
    chk({22'h0, progress_bar}, 32'h3c0);
    p.slide(8'h00);
    settle;
    chk({24'h0, program_bus}, 32'h0);
    $display("test fader ended");
    xfer(1, `VTS_OFS_CTRL, 32'h08);
    settle;
    chk({31'h0, preview_first_key_select_on}, 32'h1);
    p.press(8);
    settle;
    chk({30'h0, first_key_select_on_air, program_bus[0]}, 32'h2);
    xfer(0, `VTS_OFS_CTRL, 0);
    chk(d, 32'h08);
    xfer(1, `VTS_OFS_PROGRAM, 32'h05);
    settle;
    chk({24'h0, program_bus}, 32'h05);
    p.press(9);
    wait_cnt(1);
    chk({31'h0, n >= 570 && n <= 640}, 32'h1);
    $display("test keys ended");
    xfer(1, `VTS_OFS_CTRL, 32'h57);
    p.press(7);
    settle;
    chk({28'h0, audio_type, audio_follow, preview_second_key_select_on}, 32'h9);
    wait_cnt(0);
    chk({31'h0, n >= 190 && n <= 230}, 32'h1);
    settle;
    chk({8'h0, program_bus, preset_bus, preview_bus}, 32'h010505);
    chk({29'h0, second_key_select_on_air, preview_second_key_select_on, first_key_select_on_air}, 32'h5);
    p.press(10);
    wait_cnt(2);
    chk({31'h0, n >= 700 && n <= 780}, 32'h1);
    $display("test pal ended");
    wrap_up;
  end
endmodule

// *** tb/vts_panel.sv ***
`timescale 1ns/100ps
// ==================================================
// operator panel: buttons give one-cycle pulses, fader is a level
module vts_panel (
  input wire logic hclk,
  output logic [10:0] btn,
  output logic [7:0] fader_pos
);
  initial begin
    btn = 11'h000;
    fader_pos = 8'h00;
  end
  // a pulse lasts one edge so one press is counted once
  task automatic press(input int i);
    @(posedge hclk);
    btn[i] <= 1'b1;
    @(posedge hclk);
    btn[i] <= 1'b0;
  endtask
  task automatic slide(input logic [7:0] p);
    @(posedge hclk);
    fader_pos <= p;
  endtask
endmodule
